// file: verilog/pdc_pkg.sv
/*
 * shared constants and types of the probe data channel: register offsets,
 * field positions, threshold codes, probe frame layout and timing counts.
 * assumes a single core clock of 200 MHz; the probe shift clock is sampled,
 * not used as a clock.
 */
`default_nettype none

package pdc_pkg;

    // data path and queue geometry
    localparam int DATA_W = 32; // one queue entry
    localparam int TX_DEPTH = 16; // core-side transmit entries
    localparam int RX_DEPTH = 16; // core-side receive entries
    localparam int CNT_W = 5; // holds 0..16
    localparam int ADDR_W = 8; // offset inside the device window

    // register offsets inside the device window (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_ID = 8'h00; // identification word
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h08; // channel_config
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10; // channel_status
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTL = 8'h14; // interrupt_control_reg
    localparam logic [ADDR_W-1:0] OFS_RX_DATA = 8'h18; // receive_queue pop
    localparam logic [ADDR_W-1:0] OFS_TX_DATA = 8'h1c; // transmit_queue push

    // identification word; the code value is arbitrary
    localparam logic [7:0] DEVICE_ID = 8'h5a;
    localparam int ID_LSB = 24;

    // threshold codes, one per direction
    localparam logic [1:0] THR_OFF = 2'h0; // interrupts disabled
    localparam logic [1:0] THR_MIN_OVH = 2'h1; // minimum core overhead
    localparam logic [1:0] THR_MIN_LAT = 2'h2; // minimum latency
    localparam logic [1:0] THR_MAX_BW = 2'h3; // maximum bandwidth

    // channel_config field positions
    localparam int CFG_RX_LSB = 0;
    localparam int CFG_TX_LSB = 2;
    localparam int CFG_RXCNT_LSB = 8;
    localparam int CFG_TX_ENTRY_COUNT_LSB = 16;

    // channel_status bit positions
    localparam int ST_TXF = 0; // tx_full_flag
    localparam int ST_TXE = 1; // tx_empty_flag
    localparam int ST_RXF = 2;
    localparam int ST_RXE = 3;
    localparam int ST_IRQ = 4; // channel_irq_pending
    localparam int ST_TX_ENTRY_COUNT_LSB = 8;
    localparam int ST_RXCNT_LSB = 16;

    // interrupt_control_reg layout
    localparam int LINE_W = 3; // irq_line_field width
    localparam int IC_LINE_LSB = 0;
    localparam int IC_EIC_BIT = 7;

    // probe frame: tx valid, rx space, then data, least significant first
    localparam int FRAME_BITS = 34;
    localparam int FRAME_CNT_W = 6;
    localparam int FR_VALID = 0;
    localparam int FR_SPACE = 1;
    localparam int FR_DATA_LSB = 2;

    // wake window for the gated core clock after a probe transfer
    localparam int CLK_PERIOD_NS = 5;
    localparam int WAKE_TIME_NS = 20;
    localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_W = 3;

    // software configuration of both thresholds
    typedef struct packed {
        logic [1:0] tx_mode;
        logic [1:0] rx_mode;
    } pdc_cfg_type;

    // one register access from the core
    typedef struct packed {
        logic sel;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pdc_req_type;

    // frame states of the probe shift port
    typedef enum logic {FRAME_IDLE, FRAME_SHIFT} pdc_frame_type;

endpackage : pdc_pkg

`default_nettype wire

// file: verilog/pdc_channel.sv
/*
 * probe data channel: a transmit queue and a receive queue between core
 * software (register window) and an external probe (serial shift port),
 * with threshold interrupts and a wake request for the gated core clock.
 * holds the queue module and the top module.
 * assumes REF_CLK runs free at 200 MHz and the probe shift clock is far
 * slower (80 ns period) so that it can be sampled and its edges found.
 */
`timescale 1ns/100ps
`default_nettype none

// generic queue: flip-flop storage, valid/ready on both sides
module pdc_fifo
    import pdc_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = TX_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CNT_W-1:0] count
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH]; // entry storage
    logic [PTR_W-1:0] wr_ptr_reg; // next slot to fill
    logic [PTR_W-1:0] rd_ptr_reg; // oldest entry
    logic [CNT_W-1:0] count_reg; // entries held
    logic push; // accepted write
    logic pop; // accepted read

    // full and empty come straight from the count, so they never lie
    assign in_ready = (count_reg != FULL_CNT);
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_reg[rd_ptr_reg];
    assign count = count_reg;

    // per-entry write
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk) begin
            if (push && (wr_ptr_reg == PTR_W'(i))) begin
                mem_reg[i] <= in_data;
            end
        end
    end

    // write pointer wraps at the depth, not at a power of two
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
        end
    end

    // read pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
        end
    end

    // occupancy; simultaneous push and pop leave it unchanged
    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end

endmodule : pdc_fifo

// Contract
// - software reaches queues by register loads/stores
// - one frame pops tx and pushes rx
// - probe traffic never stalls the core
// - identification word readable in window
// - pending interrupt shown on cause bit
// - interrupt also driven on core output
// - line select reflected outside external mode
// - channel interrupt is ordinary, never debug
// - independent thresholds, ORed into one interrupt
// - disabled threshold gives no interrupt
// - overhead mode: rx full, tx empty
// - latency mode: rx not empty, tx not full
// - bandwidth mode: zero/one free or used
// - both holding registers act as entries
// - tx full when core entries are full
// - tx almost empty when core entries empty
// - no almost-empty while core entry holds data
// - transfers proceed while the core sleeps
// - sampled probe pins enable gated clock briefly
// - sleep transfers may raise waking interrupt
module pdc_channel
    import pdc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic REG_SEL,
    input wire logic REG_WR,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    output logic [DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic PROBE_SHIFT_CLOCK,
    input wire logic PROBE_SEL,
    input wire logic PROBE_DI,
    output logic PROBE_DO,
    input wire logic EXTERNAL_IRQ_CONTROLLER_MODE,
    input wire logic [LINE_W-1:0] CHANNEL_IRQ_LINE_SELECT,
    output logic CHANNEL_IRQ_OUT,
    output logic CHANNEL_IRQ_PENDING,
    output logic GATED_CLK_EN
);
    localparam logic [FRAME_CNT_W-1:0] FRAME_LEN = FRAME_CNT_W'(FRAME_BITS);
    localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_CYCLES);
    localparam logic [CNT_W-1:0] RX_FULL_CNT = CNT_W'(RX_DEPTH);
    localparam logic [CNT_W-1:0] RX_NEAR_CNT = CNT_W'(RX_DEPTH - 1);

    pdc_req_type req; // bundled register access
    pdc_cfg_type cfg_reg; // threshold modes
    pdc_frame_type frame_reg; // probe shift state

    // three-stage samplers for the probe pins; stage one feeds stage two only
    logic [2:0] clk_sync_reg;
    logic [2:0] sel_sync_reg;
    logic [2:0] di_sync_reg;
    logic clk_level_reg; // accepted level of the probe clock
    logic sel_level_reg; // accepted level of the frame select
    logic clk_rise; // accepted rising edge of the probe clock
    logic sel_rise; // frame opens
    logic sel_fall; // frame closes

    // shift port
    logic [FRAME_BITS-1:0] shift_out_reg; // bits still to send
    logic [FRAME_BITS-1:0] shift_in_reg; // bits received so far
    logic [FRAME_CNT_W-1:0] bit_cnt_reg; // saturates at the frame length
    logic tx_offer_reg; // this frame carries a tx entry
    logic rx_offer_reg; // this frame may deliver an rx entry
    logic frame_done; // complete frame closed

    // link-side holding entries of each direction
    logic [DATA_W-1:0] tx_link_reg;
    logic tx_link_valid_reg;
    logic [DATA_W-1:0] rx_link_reg;
    logic rx_link_valid_reg;

    // queue hookup
    logic tx_in_valid;
    logic tx_in_ready;
    logic tx_out_valid;
    logic tx_out_ready;
    logic [DATA_W-1:0] tx_out_data;
    logic [CNT_W-1:0] tx_count;
    logic rx_in_ready;
    logic rx_out_valid;
    logic rx_out_ready;
    logic [DATA_W-1:0] rx_out_data;
    logic [CNT_W-1:0] rx_count;

    // interrupt terms
    logic rx_irq;
    logic tx_irq;
    logic irq_reg;
    logic [WAKE_W-1:0] wake_cnt_reg;
    logic [DATA_W-1:0] rdata_next;

    assign req = '{sel: REG_SEL, wr: REG_WR, addr: REG_ADDR, wdata: REG_WDATA};

    // pin samplers: a level is accepted once stages two and three agree
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            clk_sync_reg <= '0;
            sel_sync_reg <= '0;
            di_sync_reg <= '0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[1:0], PROBE_SHIFT_CLOCK};
            sel_sync_reg <= {sel_sync_reg[1:0], PROBE_SEL};
            di_sync_reg <= {di_sync_reg[1:0], PROBE_DI};
        end
    end

    assign clk_rise = (clk_sync_reg[1] == clk_sync_reg[2]) && clk_sync_reg[2] && !clk_level_reg;
    assign sel_rise = (sel_sync_reg[1] == sel_sync_reg[2]) && sel_sync_reg[2] && !sel_level_reg;
    assign sel_fall = (sel_sync_reg[1] == sel_sync_reg[2]) && !sel_sync_reg[2] && sel_level_reg;

    // accepted levels; a one-sample glitch never reaches the frame logic
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            clk_level_reg <= 1'b0;
            sel_level_reg <= 1'b0;
        end else begin
            if (clk_sync_reg[1] == clk_sync_reg[2]) begin
                clk_level_reg <= clk_sync_reg[2];
            end
            if (sel_sync_reg[1] == sel_sync_reg[2]) begin
                sel_level_reg <= sel_sync_reg[2];
            end
        end
    end

    // frame state: only a select window moves data for the probe
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            frame_reg <= FRAME_IDLE;
        end else begin
            case (frame_reg)
                FRAME_IDLE: begin
                    if (sel_rise) begin
                        frame_reg <= FRAME_SHIFT;
                    end
                end
                FRAME_SHIFT: begin
                    if (sel_fall) begin
                        frame_reg <= FRAME_IDLE;
                    end
                end
                default: begin
                    frame_reg <= FRAME_IDLE;
                end
            endcase
        end
    end

    // a short frame is dropped whole, so a probe abort never half-moves data
    assign frame_done = (frame_reg == FRAME_SHIFT) && sel_fall && (bit_cnt_reg == FRAME_LEN);

    // shift registers: snapshot at frame open, one bit per probe clock rise
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            shift_out_reg <= '0;
            shift_in_reg <= '0;
            bit_cnt_reg <= '0;
            tx_offer_reg <= 1'b0;
            rx_offer_reg <= 1'b0;
        end else if ((frame_reg == FRAME_IDLE) && sel_rise) begin
            // status bits lead so the probe can poll and drain
            shift_out_reg <= {tx_link_reg, !rx_link_valid_reg, tx_link_valid_reg};
            bit_cnt_reg <= '0;
            tx_offer_reg <= tx_link_valid_reg;
            rx_offer_reg <= !rx_link_valid_reg;
        end else if ((frame_reg == FRAME_SHIFT) && clk_rise) begin
            shift_out_reg <= {1'b0, shift_out_reg[FRAME_BITS-1:1]};
            shift_in_reg <= {di_sync_reg[2], shift_in_reg[FRAME_BITS-1:1]};
            if (bit_cnt_reg != FRAME_LEN) begin
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
            end
        end
    end

    // serial output: next bit appears after the rise; probe samples on the fall
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            PROBE_DO <= 1'b0;
        end else if ((frame_reg == FRAME_IDLE) && sel_rise) begin
            PROBE_DO <= tx_link_valid_reg;
        end else if ((frame_reg == FRAME_SHIFT) && clk_rise) begin
            PROBE_DO <= shift_out_reg[1];
        end
    end

    // software writes land in the transmit queue; a full queue drops them
    assign tx_in_valid = req.sel && req.wr && (req.addr == OFS_TX_DATA);
    // refill the link entry only between frames, so the snapshot stays true
    assign tx_out_ready = !tx_link_valid_reg && (frame_reg == FRAME_IDLE);

    pdc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(TX_DEPTH)
    ) u_tx_queue (
        .clk(REF_CLK),
        .rst(RST),
        .in_valid(tx_in_valid),
        .in_ready(tx_in_ready),
        .in_data(req.wdata),
        .out_valid(tx_out_valid),
        .out_ready(tx_out_ready),
        .out_data(tx_out_data),
        .count(tx_count)
    );

    // link-side tx entry: one more queue slot beyond the core entries
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tx_link_valid_reg <= 1'b0;
            tx_link_reg <= '0;
        end else if (tx_out_valid && tx_out_ready) begin
            tx_link_valid_reg <= 1'b1;
            tx_link_reg <= tx_out_data;
        end else if (frame_done && tx_offer_reg) begin
            tx_link_valid_reg <= 1'b0; // same frame may also deliver rx
        end
    end

    // link-side rx entry, filled by a frame and drained into the queue
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rx_link_valid_reg <= 1'b0;
            rx_link_reg <= '0;
        end else if (frame_done && rx_offer_reg && shift_in_reg[FR_VALID]) begin
            rx_link_valid_reg <= 1'b1; // only offered when empty, no clash
            rx_link_reg <= shift_in_reg[FRAME_BITS-1:FR_DATA_LSB];
        end else if (rx_link_valid_reg && rx_in_ready) begin
            rx_link_valid_reg <= 1'b0;
        end
    end

    // reading the rx data word pops it; reads of an empty queue return zero
    assign rx_out_ready = req.sel && !req.wr && (req.addr == OFS_RX_DATA);

    pdc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(RX_DEPTH)
    ) u_rx_queue (
        .clk(REF_CLK),
        .rst(RST),
        .in_valid(rx_link_valid_reg),
        .in_ready(rx_in_ready),
        .in_data(rx_link_reg),
        .out_valid(rx_out_valid),
        .out_ready(rx_out_ready),
        .out_data(rx_out_data),
        .count(rx_count)
    );

    // threshold configuration, written by software
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cfg_reg <= '{tx_mode: THR_OFF, rx_mode: THR_OFF};
        end else if (req.sel && req.wr && (req.addr == OFS_CONFIG)) begin
            cfg_reg.rx_mode <= req.wdata[CFG_RX_LSB+:2]; // independent per side
            cfg_reg.tx_mode <= req.wdata[CFG_TX_LSB+:2];
        end
    end

    // receive request by threshold; counts are core-side entries only
    always_comb begin
        case (cfg_reg.rx_mode)
            THR_OFF: rx_irq = 1'b0;
            THR_MIN_OVH: rx_irq = (rx_count == RX_FULL_CNT);
            THR_MIN_LAT: rx_irq = rx_out_valid;
            THR_MAX_BW: rx_irq = (rx_count >= RX_NEAR_CNT);
            default: rx_irq = 1'b0;
        endcase
    end

    // transmit request; almost empty looks only at the core entries, so a
    // single word still waiting there does not raise it
    always_comb begin
        case (cfg_reg.tx_mode)
            THR_OFF: tx_irq = 1'b0;
            THR_MIN_OVH: tx_irq = !tx_out_valid && !tx_link_valid_reg;
            THR_MIN_LAT: tx_irq = tx_in_ready;
            THR_MAX_BW: tx_irq = !tx_out_valid;
            default: tx_irq = 1'b0;
        endcase
    end

    // one ordinary level interrupt; it runs off the free clock so a transfer
    // during sleep can wake the core, and no debug path exists
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= rx_irq || tx_irq;
        end
    end

    // cause bit and the output pin each take their own flop
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            CHANNEL_IRQ_PENDING <= 1'b0;
            CHANNEL_IRQ_OUT <= 1'b0;
        end else begin
            CHANNEL_IRQ_PENDING <= rx_irq || tx_irq;
            CHANNEL_IRQ_OUT <= rx_irq || tx_irq;
        end
    end

    // wake window: after each completed frame or link refill the gated core
    // clock is asked for a few cycles, then released again
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            wake_cnt_reg <= '0;
        end else if (frame_done || (tx_out_valid && tx_out_ready)
                     || (rx_link_valid_reg && rx_in_ready)) begin
            wake_cnt_reg <= WAKE_LOAD;
        end else if (wake_cnt_reg != '0) begin
            wake_cnt_reg <= wake_cnt_reg - 1'b1;
        end
    end

    // clock enable request, registered
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            GATED_CLK_EN <= 1'b0;
        end else begin
            GATED_CLK_EN <= (wake_cnt_reg != '0);
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_next = '0;
        case (req.addr)
            OFS_ID: begin
                rdata_next[ID_LSB+:8] = DEVICE_ID;
            end
            OFS_CONFIG: begin
                rdata_next[CFG_RX_LSB+:2] = cfg_reg.rx_mode;
                rdata_next[CFG_TX_LSB+:2] = cfg_reg.tx_mode;
                rdata_next[CFG_RXCNT_LSB+:CNT_W] = CNT_W'(RX_DEPTH);
                rdata_next[CFG_TX_ENTRY_COUNT_LSB+:CNT_W] = CNT_W'(TX_DEPTH);
            end
            OFS_STATUS: begin
                // full means the core entries, even with the link entry free
                rdata_next[ST_TXF] = !tx_in_ready;
                rdata_next[ST_TXE] = !tx_out_valid && !tx_link_valid_reg;
                rdata_next[ST_RXF] = !rx_in_ready;
                rdata_next[ST_RXE] = !rx_out_valid;
                rdata_next[ST_IRQ] = irq_reg;
                rdata_next[ST_TX_ENTRY_COUNT_LSB+:CNT_W] = tx_count;
                rdata_next[ST_RXCNT_LSB+:CNT_W] = rx_count;
            end
            OFS_IRQ_CTL: begin
                // line number only has meaning outside external mode
                if (!EXTERNAL_IRQ_CONTROLLER_MODE) begin
                    rdata_next[IC_LINE_LSB+:LINE_W] = CHANNEL_IRQ_LINE_SELECT;
                end
                rdata_next[IC_EIC_BIT] = EXTERNAL_IRQ_CONTROLLER_MODE;
            end
            OFS_RX_DATA: begin
                rdata_next = rx_out_valid ? rx_out_data : '0;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // every read answers on the next edge; probe activity never holds it
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            REG_RDATA <= '0;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= req.sel && !req.wr;
            if (req.sel && !req.wr) begin
                REG_RDATA <= rdata_next;
            end
        end
    end

endmodule : pdc_channel

`default_nettype wire

// file: tb/pdc_channel_props.sv
/* assertions on the channel top ports, bound to pdc_channel.
   assumes the single REF_CLK domain and synchronous RST. */
`timescale 1ns/100ps
`default_nettype none
module pdc_channel_props import pdc_pkg::*; (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic REG_SEL,
    input wire logic REG_WR,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic EXTERNAL_IRQ_CONTROLLER_MODE,
    input wire logic [LINE_W-1:0] CHANNEL_IRQ_LINE_SELECT,
    input wire logic CHANNEL_IRQ_OUT,
    input wire logic CHANNEL_IRQ_PENDING,
    input wire logic GATED_CLK_EN
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    wire logic rd = REG_SEL && !REG_WR; // read taken this edge
    wire logic wr = REG_SEL && REG_WR; // write taken this edge
    wire logic ctl = REG_ADDR == OFS_IRQ_CTL; // irq control offset
    AST_RVALID: assert property (rd |=> REG_RVALID)
        else $error("read not answered");
    AST_NORV: assert property (!rd |=> !REG_RVALID)
        else $error("answer without read");
    AST_ID: assert property (rd && REG_ADDR == OFS_ID |=> REG_RDATA[31:24] == DEVICE_ID)
        else $error("bad id word");
    AST_CFG: assert property (rd && REG_ADDR == OFS_CONFIG |=>
        {REG_RDATA[20:16], REG_RDATA[12:8]} == {5'(TX_DEPTH), 5'(RX_DEPTH)})
        else $error("bad depth fields");
    AST_LINE: assert property (rd && ctl && !EXTERNAL_IRQ_CONTROLLER_MODE |=>
        REG_RDATA[2:0] == $past(CHANNEL_IRQ_LINE_SELECT))
        else $error("line select not shown");
    AST_EXT: assert property (rd && ctl && EXTERNAL_IRQ_CONTROLLER_MODE |=>
        REG_RDATA[7:0] == 8'h80)
        else $error("bad external mode field");
    // both modes off must silence the line within two edges
    AST_OFF: assert property (wr && REG_ADDR == OFS_CONFIG && REG_WDATA[3:0] == 4'h0
        |-> ##2 !CHANNEL_IRQ_OUT)
        else $error("irq while disabled");
    AST_PEND: assert property (CHANNEL_IRQ_PENDING == CHANNEL_IRQ_OUT)
        else $error("cause bit differs from irq pin");
    // a refill or drain just after a frame restarts the window, so it may run longer
    AST_WAKE: assert property ($rose(GATED_CLK_EN) |->
        GATED_CLK_EN [*4] ##[1:8] !GATED_CLK_EN)
        else $error("wake window out of range");
    cover property (rd && REG_ADDR == OFS_RX_DATA);
    cover property ($rose(GATED_CLK_EN));
    cover property ($rose(CHANNEL_IRQ_OUT));
endmodule : pdc_channel_props
bind pdc_channel pdc_channel_props u_props (.REF_CLK, .RST, .REG_SEL, .REG_WR, .REG_ADDR,
    .REG_WDATA, .REG_RDATA, .REG_RVALID, .EXTERNAL_IRQ_CONTROLLER_MODE,
    .CHANNEL_IRQ_LINE_SELECT, .CHANNEL_IRQ_OUT, .CHANNEL_IRQ_PENDING, .GATED_CLK_EN);
`default_nettype wire

// file: tb/pdc_probe_model.sv
/* probe model: shifts 34-bit channel frames at an 80 ns shift clock.
   assumes the bench calls frame() and waits for it to return. */
`timescale 1ns/100ps
`default_nettype none
module pdc_probe_model (
    output logic sclk,
    output logic sel,
    output logic di,
    input wire logic dout
);
    initial begin
        sclk = 1'b0;
        sel = 1'b0;
        di = 1'b0;
    end
    // shift clock runs only inside a frame, never free
    task automatic frame(input logic [33:0] din, output logic [33:0] dq);
        sel = 1'b1;
        #80 dq[0] = dout;
        for (int k = 0; k < 34; k++) begin
            di = din[k];
            #40 sclk = 1'b1;
            #40 sclk = 0;
            if (k < 33) dq[k+1] = dout; // sampled on the falling edge
        end
        sel = 1'b0;
        di = ~di; // released line shows no stale level
        #240; // gap lets the tx link entry refill
    endtask : frame
endmodule : pdc_probe_model
`default_nettype wire

// file: tb/pdc_channel_tb.sv
/* self-checking bench of pdc_channel with the probe model.
   assumes a 200 MHz REF_CLK; seed 61 makes the run repeatable. */
`timescale 1ns/100ps
`default_nettype none
module pdc_channel_tb import pdc_pkg::*; ;
    logic clk, rst, sel, wr, ext, sclk, psel, pdi, pdo, rv, irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, rdat, v;
    logic [LINE_W-1:0] line;
    logic [33:0] fo;
    logic [1:0] m;
    logic [DATA_W-1:0] txq[$], rxq[$]; // words in flight per direction
    int errors, cmp_count, rxc;
    integer seed = 61;
    pdc_channel dut (.REF_CLK(clk), .RST(rst), .REG_SEL(sel), .REG_WR(wr), .REG_ADDR(addr),
        .REG_WDATA(wd), .REG_RDATA(rdat), .REG_RVALID(rv), .PROBE_SHIFT_CLOCK(sclk),
        .PROBE_SEL(psel), .PROBE_DI(pdi), .PROBE_DO(pdo), .EXTERNAL_IRQ_CONTROLLER_MODE(ext),
        .CHANNEL_IRQ_LINE_SELECT(line), .CHANNEL_IRQ_OUT(irq), .CHANNEL_IRQ_PENDING(),
        .GATED_CLK_EN());
    pdc_probe_model u_probe (.sclk(sclk), .sel(psel), .di(pdi), .dout(pdo));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        {sel, wr, addr, wd} = {2'b11, a, d};
        @(negedge clk);
        sel = 1'b0;
    endtask : wreg
    // the answer is registered at the taking edge, so it is settled here
    task automatic rreg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge clk);
        {sel, wr, addr} = {2'b10, a};
        @(negedge clk);
        sel = 1'b0;
        d = (rv === 1'b1) ? rdat : 'x;
    endtask : rreg
    // mode is {tx mode, rx mode}; the line follows a few cycles later
    task automatic ckirq(input logic [3:0] mode, input logic e);
        wreg(OFS_CONFIG, 32'(mode));
        repeat (3) @(negedge clk);
        chk(32'(irq), 32'(e));
    endtask : ckirq
    task automatic results;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        #400000;
        errors++;
        results();
    end
    initial begin
        {rst, sel, wr, addr, wd, ext} = {1'b1, 43'h0};
        line = 3'($random(seed));
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        rreg(OFS_ID, v);
        chk(v >> ID_LSB, 32'(DEVICE_ID));
        rreg(OFS_CONFIG, v);
        chk(v, 32'h0010_1000);
        rreg(OFS_STATUS, v);
        chk(v, 32'h0000_000a);
        rreg(OFS_IRQ_CTL, v);
        chk(v, 32'(line));
        ext = 1'b1;
        rreg(OFS_IRQ_CTL, v);
        chk(v, 32'h80);
        rreg(8'h40, v);
        chk(v, 32'h0);
        for (int i = 0; i < 20; i++) begin
            rreg(OFS_STATUS, v);
            if (v[ST_TXF]) break; // software polls full first
            txq.push_back($random(seed));
            wreg(OFS_TX_DATA, txq[$]);
        end
        chk(v & 32'h1f03, 32'h1001);
        chk(32'(txq.size() >= 16), 1);
        wreg(OFS_TX_DATA, 32'hdead_beef); // dropped while full
        ckirq(4'h4, 0);
        ckirq(4'h8, 0);
        ckirq(4'hc, 0);
        while (txq.size() > 0) begin
            v = $random(seed);
            u_probe.frame({v, 2'b01}, fo);
            chk(32'(fo[FR_VALID]), 1);
            chk(fo[33:2], txq.pop_front());
            if (fo[FR_SPACE]) rxq.push_back(v);
        end
        u_probe.frame(34'h0, fo);
        chk(32'(fo[FR_VALID]), 0);
        ckirq(4'h4, 1);
        ckirq(4'h8, 1);
        ckirq(4'hc, 1);
        while (rxq.size() > 0) begin
            rxc = (rxq.size() > 16) ? 16 : rxq.size();
            m = 2'(rxq.size() % 4);
            ckirq({2'h0, m}, m == 1 ? rxc == 16 : m == 2 ? rxc > 0 : m == 3 && rxc >= 15);
            rreg(OFS_RX_DATA, v);
            chk(v, rxq.pop_front());
        end
        rreg(OFS_RX_DATA, v);
        chk(v, 32'h0);
        ckirq(4'h6, 1);
        ckirq(4'h2, 0);
        ckirq(4'h0, 0);
        results();
    end
endmodule : pdc_channel_tb
`default_nettype wire
